// [sdci_core.sv]
// Command decode and bank control of a four-bank synchronous DRAM.
// Assumes the controller pins arrive unsynchronised and the cell array
// sits outside, answering a read in the same cycle it is addressed.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sdci_core #(
  parameter sdci_pkg::sdci_org_t ORG = sdci_pkg::SDCI_X16,
  parameter int PRE_CYC              = sdci_pkg::PRECHARGE_PERIOD_CYC,
  parameter int PRE_W                = 4
) (
  input  wire logic                             i_mclk,
  input  wire logic                             i_reset,
  input  wire logic                             i_cke,
  input  wire logic                             i_cs_n,
  input  wire logic                             i_ras_n,
  input  wire logic                             i_cas_n,
  input  wire logic                             i_we_n,
  input  wire logic                             i_bank_select_low,
  input  wire logic                             i_bank_select_high,
  input  wire logic [sdci_pkg::ADDR_W-1:0]      i_addr,
  input  wire logic [sdci_pkg::LANES-1:0]       i_dqm,
  input  wire logic [sdci_pkg::DQ_W-1:0]        i_dq,
  output logic      [sdci_pkg::DQ_W-1:0]        o_dq,
  output logic      [sdci_pkg::LANES-1:0]       o_dq_oe,
  output logic                                  o_arr_we,
  output logic                                  o_arr_re,
  output logic      [sdci_pkg::BANK_W-1:0]      o_arr_bank,
  output logic      [sdci_pkg::ROW_W-1:0]       o_arr_row,
  output logic      [sdci_pkg::COL_W-1:0]       o_arr_col,
  output logic      [sdci_pkg::DQ_W-1:0]        o_arr_wdata,
  output logic      [sdci_pkg::LANES-1:0]       o_arr_lane_we,
  input  wire logic [sdci_pkg::DQ_W-1:0]        i_arr_rdata,
  output logic                                  o_refresh,
  output logic      [sdci_pkg::ROW_W-1:0]       o_refresh_row,
  output logic                                  o_self_refresh,
  output logic      [sdci_pkg::BANKS-1:0]       o_bank_open,
  output logic      [sdci_pkg::MODE_W-1:0]      o_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  generate
    if (PRE_CYC < 1 || PRE_CYC >= (1 << PRE_W)) begin : g_bad_pre
      $error("Precharge count does not fit its counter");
    end
  endgenerate

  localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(PRE_CYC);
  localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);

  // Lanes that carry data for the chosen organisation
  localparam logic [sdci_pkg::LANES-1:0] LANE_USED =
    (ORG == sdci_pkg::SDCI_X16) ? 2'h3 : 2'h1;

  // Column space of one row
  localparam logic [sdci_pkg::COL_W-1:0] COL_MASK =
    (ORG == sdci_pkg::SDCI_X4) ? sdci_pkg::COL_MASK_X4 :
    (ORG == sdci_pkg::SDCI_X8) ? sdci_pkg::COL_MASK_X8 :
                                 sdci_pkg::COL_MASK_X16;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    sdci_pkg::sdci_pins_t                                   p1;
    sdci_pkg::sdci_pins_t                                   p2;
    logic [sdci_pkg::MODE_W-1:0]                            mode;
    logic [sdci_pkg::BANKS-1:0]                             open;
    logic [sdci_pkg::BANKS-1:0][sdci_pkg::ROW_W-1:0]        row;
    logic [sdci_pkg::BANKS-1:0][PRE_W-1:0]                  pre;
    logic [sdci_pkg::BANK_W-1:0]                            bbank;
    logic                                                   bauto;
    logic                                                   selfref;
    logic                                                   refresh;
    logic [sdci_pkg::ROW_W-1:0]                             rcount;
    logic [sdci_pkg::ROW_W-1:0]                             rrow;
    logic                                                   acc_we;
    logic                                                   acc_re;
    logic [sdci_pkg::BANK_W-1:0]                            acc_bank;
    logic [sdci_pkg::ROW_W-1:0]                             acc_row;
    logic [sdci_pkg::COL_W-1:0]                             acc_col;
    logic [sdci_pkg::DQ_W-1:0]                              acc_wdata;
    logic [sdci_pkg::LANES-1:0]                             acc_lane_we;
    logic                                                   pipe_vld;
    logic [sdci_pkg::DQ_W-1:0]                              pipe_data;
    logic [sdci_pkg::LANES-1:0]                             dqm_p;
    logic [sdci_pkg::DQ_W-1:0]                              dq;
    logic [sdci_pkg::LANES-1:0]                             oe;
  } sdci_core_t;

  sdci_core_t q;
  sdci_core_t d;
  sdci_pkg::sdci_cmd_t cmd;
  sdci_pkg::sdci_pins_t pin;
  sdci_pkg::sdci_pins_t s;
  logic [sdci_pkg::COL_W-1:0] col;
  logic [sdci_pkg::MR_CL_W-1:0] cl;
  logic [sdci_pkg::BANK_W-1:0] abank;
  logic rd_vld;
  logic [sdci_pkg::DQ_W-1:0] rd_data;

  sdci_burst_if bif ();

  sdci_burst u_burst (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .bus     (bif.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture
  always_comb begin
    pin.cke   = i_cke;
    pin.sel   = ~i_cs_n;
    pin.ras_n = i_ras_n;
    pin.cas_n = i_cas_n;
    pin.we_n  = i_we_n;
    pin.bank  = {i_bank_select_high, i_bank_select_low};
    pin.addr  = i_addr;
    pin.dqm   = i_dqm;
    pin.dq    = i_dq;
  end

  assign s = q.p2;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode on the sampled edge
  always_comb begin
    if (!s.sel || q.selfref) begin
      cmd = sdci_pkg::CMD_INHIBIT;
    end else begin
      case ({s.ras_n, s.cas_n, s.we_n})
        3'h7:    cmd = sdci_pkg::CMD_NOP;
        3'h3:    cmd = sdci_pkg::CMD_ACTIVATE;
        3'h5:    cmd = sdci_pkg::CMD_READ;
        3'h4:    cmd = sdci_pkg::CMD_WRITE;
        3'h6:    cmd = sdci_pkg::CMD_TERMINATE;
        3'h2:    cmd = sdci_pkg::CMD_PRECHARGE;
        3'h1:    cmd = sdci_pkg::CMD_REFRESH;
        3'h0:    cmd = sdci_pkg::CMD_MODE_LOAD;
        default: cmd = sdci_pkg::CMD_NOP;
      endcase
    end
  end

  // Starting column by organisation
  always_comb begin
    case (ORG)
      sdci_pkg::SDCI_X4:
        col = {s.addr[sdci_pkg::ADDR_TOP_BIT], s.addr[9:0]};
      sdci_pkg::SDCI_X8:
        col = {1'b0, s.addr[9:0]};
      default:
        col = {2'h0, s.addr[8:0]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst request
  logic access_ok;

  always_comb begin
    access_ok = ((cmd == sdci_pkg::CMD_READ) || (cmd == sdci_pkg::CMD_WRITE)) &&
                q.open[s.bank];
    bif.start      = access_ok;
    bif.is_write   = (cmd == sdci_pkg::CMD_WRITE);
    bif.col        = col;
    bif.interleave = q.mode[sdci_pkg::MR_TYPE_BIT];
    bif.col_mask   = COL_MASK;
    // Single-write mode shortens write bursts to one column
    if (bif.is_write && q.mode[sdci_pkg::MR_WB_BIT]) begin
      bif.len_code = sdci_pkg::BL_1;
    end else begin
      bif.len_code = q.mode[sdci_pkg::MR_BL_LSB +: sdci_pkg::MR_BL_W];
    end
    // Closing the burst's bank also cuts the burst short
    bif.stop = (cmd == sdci_pkg::CMD_TERMINATE) ||
               ((cmd == sdci_pkg::CMD_PRECHARGE) &&
                (s.addr[sdci_pkg::AUTO_CLOSE_BIT] || (s.bank == q.bbank)));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read return path
  always_comb begin
    cl = q.mode[sdci_pkg::MR_CL_LSB +: sdci_pkg::MR_CL_W];
    // Latency below two is not served: the array access is registered
    if (cl == sdci_pkg::CL_3) begin
      rd_vld  = q.pipe_vld;
      rd_data = q.pipe_data;
    end else begin
      rd_vld  = q.acc_re;
      rd_data = i_arr_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.p1 = pin;
    d.p2 = q.p1;
    d.refresh = 1'b0;
    abank = bif.start ? s.bank : q.bbank;

    if (bif.start) begin
      d.bbank = s.bank;
      d.bauto = s.addr[sdci_pkg::AUTO_CLOSE_BIT];
    end

    // Array access, one column per cycle of the burst
    d.acc_we      = bif.valid & bif.write;
    d.acc_re      = bif.valid & ~bif.write;
    d.acc_bank    = abank;
    d.acc_row     = q.row[abank];
    d.acc_col     = bif.cur_col;
    d.acc_wdata   = s.dq;
    d.acc_lane_we = ~s.dqm & LANE_USED;

    for (int b = 0; b < sdci_pkg::BANKS; b++) begin
      if (q.pre[b] != '0) begin
        d.pre[b] = q.pre[b] - PRE_ONE;
      end
      if ((cmd == sdci_pkg::CMD_ACTIVATE) && (s.bank == b[sdci_pkg::BANK_W-1:0]) &&
          !q.open[b] && (q.pre[b] == '0)) begin
        d.open[b] = 1'b1;
        d.row[b]  = s.addr;
      end
      if ((cmd == sdci_pkg::CMD_PRECHARGE) && q.open[b] &&
          (s.addr[sdci_pkg::AUTO_CLOSE_BIT] || (s.bank == b[sdci_pkg::BANK_W-1:0]))) begin
        d.open[b] = 1'b0;
        d.pre[b]  = PRE_LOAD;
      end
      // Burst end with auto close; a truncated burst leaves the row open
      if (bif.valid && bif.last && d.bauto && (abank == b[sdci_pkg::BANK_W-1:0])) begin
        d.open[b] = 1'b0;
        d.pre[b]  = PRE_LOAD;
      end
    end

    if (cmd == sdci_pkg::CMD_REFRESH) begin
      if (s.cke) begin
        d.refresh = 1'b1;
        d.rrow    = q.rcount;
        d.rcount  = q.rcount + 12'h001;
      end else begin
        d.selfref = 1'b1;
      end
    end
    // Self refresh holds until the clock enable is seen high again
    if (q.selfref && s.cke) begin
      d.selfref = 1'b0;
    end

    if (cmd == sdci_pkg::CMD_MODE_LOAD) begin
      d.mode = {s.bank, s.addr};
    end

    d.pipe_vld  = q.acc_re;
    d.pipe_data = i_arr_rdata;
    d.dqm_p     = s.dqm;
    d.dq        = rd_data;
    d.oe        = {sdci_pkg::LANES{rd_vld}} & ~q.dqm_p & LANE_USED;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_dq           = q.dq;
  assign o_dq_oe        = q.oe;
  assign o_arr_we       = q.acc_we;
  assign o_arr_re       = q.acc_re;
  assign o_arr_bank     = q.acc_bank;
  assign o_arr_row      = q.acc_row;
  assign o_arr_col      = q.acc_col;
  assign o_arr_wdata    = q.acc_wdata;
  assign o_arr_lane_we  = q.acc_lane_we;
  assign o_refresh      = q.refresh;
  assign o_refresh_row  = q.rrow;
  assign o_self_refresh = q.selfref;
  assign o_bank_open    = q.open;
  assign o_mode         = q.mode;

endmodule

// [sdci_pkg.sv]
// Shared constants and types of the SDRAM command interface.
// Assumes a single 40 MHz clock; every width and count but the precharge counter width lives here.
package sdci_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_PS       = 25000;
  localparam int PRECHARGE_PERIOD_PS = 20000;
  localparam int PRECHARGE_PERIOD_CYC_RAW =
    (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRECHARGE_PERIOD_CYC =
    (PRECHARGE_PERIOD_CYC_RAW < 1) ? 1 : PRECHARGE_PERIOD_CYC_RAW;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int BANKS     = 4;
  localparam int BANK_W    = 2;
  localparam int ROW_W     = 12;
  localparam int ADDR_W    = 12;
  localparam int COL_W     = 11;
  localparam int DQ_W      = 16;
  localparam int LANES     = 2;
  localparam int MODE_W    = 14;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int ADDR_TOP_BIT   = 11;
  localparam logic [COL_W-1:0] COL_MASK_X4  = 11'h7ff;
  localparam logic [COL_W-1:0] COL_MASK_X8  = 11'h3ff;
  localparam logic [COL_W-1:0] COL_MASK_X16 = 11'h1ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register layout
  localparam int MR_BL_LSB   = 0;
  localparam int MR_BL_W     = 3;
  localparam int MR_TYPE_BIT = 3;
  localparam int MR_CL_LSB   = 4;
  localparam int MR_CL_W     = 3;
  localparam int MR_WB_BIT   = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;
  localparam logic [MR_BL_W-1:0] BL_1    = 3'h0;
  localparam logic [MR_BL_W-1:0] BL_2    = 3'h1;
  localparam logic [MR_BL_W-1:0] BL_4    = 3'h2;
  localparam logic [MR_BL_W-1:0] BL_8    = 3'h3;
  localparam logic [MR_BL_W-1:0] BL_PAGE = 3'h7;
  localparam logic [MR_CL_W-1:0] CL_3    = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {SDCI_X4, SDCI_X8, SDCI_X16} sdci_org_t;

  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD
  } sdci_cmd_t;

  // Chip select held active high so an all-zero reset means deselected
  typedef struct packed {
    logic              cke;
    logic              sel;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  dqm;
    logic [DQ_W-1:0]   dq;
  } sdci_pins_t;

endpackage

// [sdci_burst_if.sv]
// Link between the command decoder and the burst column generator.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface sdci_burst_if;
  logic                        start;
  logic                        is_write;
  logic [sdci_pkg::COL_W-1:0]  col;
  logic [sdci_pkg::MR_BL_W-1:0] len_code;
  logic                        interleave;
  logic [sdci_pkg::COL_W-1:0]  col_mask;
  logic                        stop;
  logic                        valid;
  logic                        write;
  logic [sdci_pkg::COL_W-1:0]  cur_col;
  logic                        last;

  modport ctrl (output start, is_write, col, len_code, interleave, col_mask, stop,
                input  valid, write, cur_col, last);
  modport gen  (input  start, is_write, col, len_code, interleave, col_mask, stop,
                output valid, write, cur_col, last);
endinterface

// [sdci_burst.sv]
// Burst column sequencer: walks the columns of one read or write burst.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ps
module sdci_burst (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  sdci_burst_if.gen bus
);

  typedef struct packed {
    logic                       active;
    logic                       write;
    logic                       ilv;
    logic                       page;
    logic [sdci_pkg::COL_W-1:0] base;
    logic [sdci_pkg::COL_W-1:0] mask;
    logic [sdci_pkg::COL_W-1:0] count;
  } sdci_bst_t;

  sdci_bst_t q;
  sdci_bst_t d;
  logic [sdci_pkg::COL_W-1:0] cnt;
  logic [sdci_pkg::COL_W-1:0] lmask;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    case (bus.len_code)
      sdci_pkg::BL_2:    lmask = 11'h001;
      sdci_pkg::BL_4:    lmask = 11'h003;
      sdci_pkg::BL_8:    lmask = 11'h007;
      sdci_pkg::BL_PAGE: lmask = bus.col_mask;
      default:           lmask = 11'h000;
    endcase
    // A new start overrides any burst still running
    if (bus.start) begin
      d.write = bus.is_write;
      d.ilv   = bus.interleave;
      d.page  = (bus.len_code == sdci_pkg::BL_PAGE);
      d.base  = bus.col;
      d.mask  = lmask;
      cnt     = 11'h000;
    end else begin
      cnt = q.count;
    end
    bus.valid = bus.start | (q.active & ~bus.stop);
    bus.write = d.write;
    // Column order within the burst block
    if (d.ilv) begin
      bus.cur_col = (d.base & ~d.mask) | ((d.base ^ cnt) & d.mask);
    end else begin
      bus.cur_col = (d.base & ~d.mask) | ((d.base + cnt) & d.mask);
    end
    // Full page bursts never end on their own
    bus.last = ~d.page & (cnt == d.mask);
    d.active = bus.valid & ~bus.last;
    d.count  = cnt + 11'h001;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// [sdci_array_model.sv]
// Behavioural cell array on the far side of the decoder's array port.
// Answers a read in the same cycle; stores only the enabled lanes.
`timescale 1ns/1ps
module sdci_array_model (
  input  wire logic        i_mclk,
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [1:0]  i_bank,
  input  wire logic [11:0] i_row,
  input  wire logic [10:0] i_col,
  input  wire logic [15:0] i_wdata,
  input  wire logic [1:0]  i_lane_we,
  output logic      [15:0] o_rdata
);
  logic [15:0] mem [logic [24:0]];
  logic [15:0] hold_q = 16'h0000;
  logic [24:0] key;
  assign key = {i_bank, i_row, i_col};
  ////////////////////////////////////////////////////////////
  // Outside a read the bus shows the inverse of its last word
  always_comb begin
    if (!i_re) o_rdata = ~hold_q;
    else if (mem.exists(key)) o_rdata = mem[key];
    else o_rdata = 16'h0000;
  end
  always @(posedge i_mclk) begin
    if (i_re) hold_q <= o_rdata;
    if (i_we) begin
      if (!mem.exists(key)) mem[key] = 16'h0000;
      if (i_lane_we[0]) mem[key][7:0] = i_wdata[7:0];
      if (i_lane_we[1]) mem[key][15:8] = i_wdata[15:8];
    end
  end
endmodule

// [sdci_core_props.sv]
// Checker of the decoder's pins against its array and status outputs.
// Bound to sdci_core in its x16 form; pins act three edges after they are driven.
`timescale 1ns/1ps
module sdci_core_props (
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic        i_cke,
  input wire logic        i_cs_n,
  input wire logic        i_ras_n,
  input wire logic        i_cas_n,
  input wire logic        i_we_n,
  input wire logic        i_bank_select_low,
  input wire logic        i_bank_select_high,
  input wire logic [11:0] i_addr,
  input wire logic [1:0]  i_dqm,
  input wire logic [15:0] i_dq,
  input wire logic [1:0]  o_dq_oe,
  input wire logic        o_arr_we,
  input wire logic        o_arr_re,
  input wire logic [1:0]  o_arr_bank,
  input wire logic [10:0] o_arr_col,
  input wire logic [15:0] o_arr_wdata,
  input wire logic [1:0]  o_arr_lane_we,
  input wire logic        o_refresh,
  input wire logic [11:0] o_refresh_row,
  input wire logic        o_self_refresh,
  input wire logic [3:0]  o_bank_open,
  input wire logic [13:0] o_mode
);
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic [2:0]  c;
    logic [1:0]  b;
    logic [11:0] a;
    logic [1:0]  m;
    logic [15:0] d;
  } sdci_pin_t;
  sdci_pin_t   p1_q, p2_q, p3_q;
  logic [11:0] rcnt_q;
  logic        live;
  assign live = !p3_q.cs_n;
  ////////////////////////////////////////////////////////////
  // Pin history, reset to a deselected bus
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      p1_q <= 37'h0800000000;
      p2_q <= 37'h0800000000;
      p3_q <= 37'h0800000000;
      rcnt_q <= 12'h000;
    end else begin
      p1_q <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank_select_high, i_bank_select_low, i_addr, i_dqm, i_dq};
      p2_q <= p1_q;
      p3_q <= p2_q;
      if (o_refresh) rcnt_q <= rcnt_q + 12'h001;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////
  chk_open_cause: assert property ((o_bank_open & ~$past(o_bank_open)) != 4'h0 |->
    live && p3_q.c == 3'h3 && (o_bank_open & ~$past(o_bank_open)) == (4'h1 << p3_q.b))
    else $error("bank opened without activation");
  chk_pre_one: assert property (live && p3_q.c == 3'h2 && !p3_q.a[10] && !$past(o_self_refresh)
    |-> !o_bank_open[p3_q.b]) else $error("single precharge left bank open");
  chk_pre_all: assert property (live && p3_q.c == 3'h2 && p3_q.a[10] && !$past(o_self_refresh)
    |-> o_bank_open == 4'h0) else $error("all-bank precharge left a bank open");
  chk_mode_load: assert property (live && p3_q.c == 3'h0 && !$past(o_self_refresh)
    |-> o_mode == {p3_q.b, p3_q.a}) else $error("mode register not loaded");
  chk_refresh_auto: assert property (o_refresh == (live && p3_q.c == 3'h1 && p3_q.cke
    && !$past(o_self_refresh))) else $error("auto refresh pulse wrong");
  chk_refresh_row: assert property (o_refresh |-> o_refresh_row == rcnt_q)
    else $error("refresh row did not step by one");
  chk_self_entry: assert property (live && p3_q.c == 3'h1 && !p3_q.cke && !$past(o_self_refresh)
    |-> o_self_refresh) else $error("self refresh not entered");
  chk_write_beat: assert property (o_arr_we |-> o_arr_wdata == p3_q.d
    && o_arr_lane_we == ~p3_q.m) else $error("write beat data or lanes wrong");
  chk_write_start: assert property (live && p3_q.c == 3'h4 && !$past(o_self_refresh)
    && o_bank_open[p3_q.b] |-> o_arr_we && o_arr_bank == p3_q.b && o_arr_col == {2'h0, p3_q.a[8:0]})
    else $error("write did not start at its column");
  chk_read_start: assert property (live && p3_q.c == 3'h5 && !$past(o_self_refresh)
    && o_bank_open[p3_q.b] |-> o_arr_re && o_arr_bank == p3_q.b && o_arr_col == {2'h0, p3_q.a[8:0]})
    else $error("read did not start at its column");
  chk_dq_mask: assert property ((o_dq_oe & $past(p3_q.m)) == 2'h0)
    else $error("masked read lane driven");
  chk_quiet_idle: assert property ((p3_q.cs_n || p3_q.c == 3'h7) |-> $stable(o_mode) && !o_refresh
    && (o_bank_open & ~$past(o_bank_open)) == 4'h0) else $error("idle cycle changed state");
  cov_write: cover property (o_arr_we);
  cov_read: cover property (o_dq_oe == 2'h3);
  cov_refresh: cover property (o_refresh);
  cov_self: cover property (o_self_refresh);
endmodule
bind sdci_core sdci_core_props chk_u (
  .i_mclk, .i_reset, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n,
  .i_bank_select_low, .i_bank_select_high, .i_addr, .i_dqm, .i_dq,
  .o_dq_oe, .o_arr_we, .o_arr_re, .o_arr_bank, .o_arr_col, .o_arr_wdata,
  .o_arr_lane_we, .o_refresh, .o_refresh_row, .o_self_refresh, .o_bank_open, .o_mode
);

// [sdram_command_interface_bench.sv]
// Self-checking bench: drives controller pins, array model answers reads.
// Uses the x16 organisation and a one-cycle precharge period.
`timescale 1ns/1ps
module sdram_command_interface_bench;
  // Code bits: {cke low, cs_n, ras_n, cas_n, we_n}
  localparam logic [4:0] NOP = 5'h07, ACT = 5'h03, RD = 5'h05, WR = 5'h04;
  localparam logic [4:0] BST = 5'h06, PRE = 5'h02, REF = 5'h01, MRS = 5'h00;
  localparam logic [4:0] SREF = 5'h11, XACT = 5'h0b;
  typedef struct packed {
    logic [1:0]  b;
    logic [11:0] r;
    logic [8:0]  c;
    logic [15:0] d;
    logic [1:0]  wm;
    logic [1:0]  rm;
    logic        ap;
    logic [15:0] e;
  } sdci_row_t;
  localparam sdci_row_t ROWS [4] = '{
    '{2'h0, 12'h001, 9'h001, 16'ha5c3, 2'h0, 2'h0, 1'b0, 16'ha5c3},
    '{2'h0, 12'h001, 9'h001, 16'h1234, 2'h1, 2'h0, 1'b1, 16'h12c3},
    '{2'h3, 12'hfff, 9'h1ff, 16'h5aa5, 2'h2, 2'h2, 1'b0, 16'h00a5},
    '{2'h2, 12'h800, 9'h100, 16'hffff, 2'h3, 2'h0, 1'b1, 16'h0000}};
  // Interleaved length-four read from column 5 after a single write to column 6
  localparam logic [15:0] BEATS [4] = '{16'h2222, 16'h1111, 16'h0000, 16'h6666};
  logic        i_mclk, i_reset, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n;
  logic        i_bank_select_low, i_bank_select_high;
  logic [11:0] i_addr, o_arr_row, o_refresh_row;
  logic [1:0]  i_dqm, o_dq_oe, o_arr_bank, o_arr_lane_we;
  logic [15:0] i_dq, i_arr_rdata, o_dq, o_arr_wdata, mm;
  logic        o_arr_we, o_arr_re, o_refresh, o_self_refresh;
  logic [10:0] o_arr_col;
  logic [3:0]  o_bank_open;
  logic [13:0] o_mode;
  int          err_total = 0;
  int          check_count = 0;
  sdci_core dut_u (.i_mclk, .i_reset, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n,
    .i_bank_select_low, .i_bank_select_high, .i_addr, .i_dqm, .i_dq, .o_dq, .o_dq_oe,
    .o_arr_we, .o_arr_re, .o_arr_bank, .o_arr_row, .o_arr_col, .o_arr_wdata, .o_arr_lane_we,
    .i_arr_rdata, .o_refresh, .o_refresh_row, .o_self_refresh, .o_bank_open, .o_mode);
  sdci_array_model mem_u (.i_mclk, .i_we(o_arr_we), .i_re(o_arr_re), .i_bank(o_arr_bank),
    .i_row(o_arr_row), .i_col(o_arr_col), .i_wdata(o_arr_wdata), .i_lane_we(o_arr_lane_we),
    .o_rdata(i_arr_rdata));
  ////////////////////////////////////////////////////////////
  task automatic cmd(input logic [4:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [1:0] m = 2'h0, input logic [15:0] d = 16'h0000);
    @(posedge i_mclk);
    i_cke <= ~c[4];
    i_cs_n <= c[3];
    {i_ras_n, i_cas_n, i_we_n} <= c[2:0];
    {i_bank_select_high, i_bank_select_low} <= b;
    i_addr <= a;
    i_dqm <= m;
    i_dq <= d;
  endtask
  // Deselect, then sample n edges later once outputs have settled
  task automatic idle(input int n);
    @(posedge i_mclk);
    i_cs_n <= 1'b1;
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // Whole run is under two hundred cycles; fifteen times that means a hang
  initial begin
    repeat (3000) @(posedge i_mclk);
    err_total++;
    finish_test();
  end
  initial begin
    {i_reset, i_cke, i_cs_n} = 3'b111;
    {i_ras_n, i_cas_n, i_we_n, i_bank_select_high, i_bank_select_low} = 5'h1f;
    i_addr = 12'h000;
    i_dqm = 2'h0;
    i_dq = 16'h0000;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    idle(1);
    chk("reset", 16'h0000, {o_mode, o_bank_open[1:0]} | {12'h000, o_bank_open});
    foreach (ROWS[i]) begin
      cmd(ACT, ROWS[i].b, ROWS[i].r);
      idle(1);
      cmd(WR, ROWS[i].b, {3'h0, ROWS[i].c}, ROWS[i].wm, ROWS[i].d);
      cmd(RD, ROWS[i].b, {1'b0, ROWS[i].ap, 1'b0, ROWS[i].c}, ROWS[i].rm);
      idle(3);
      mm = {{8{~ROWS[i].rm[1]}}, {8{~ROWS[i].rm[0]}}};
      chk("oe", {14'h0, ~ROWS[i].rm}, {14'h0, o_dq_oe});
      chk("rdata", ROWS[i].e & mm, o_dq & mm);
      idle(1);
      chk("autoclose", {15'h0, ~ROWS[i].ap}, {15'h0, o_bank_open[ROWS[i].b]});
      cmd(PRE, 2'h0, 12'h400);
      idle(3);
    end
    cmd(ACT, 2'h0, 12'h010);
    cmd(ACT, 2'h2, 12'h020);
    cmd(PRE, 2'h2, 12'h000);
    idle(3);
    chk("pre_one", 16'h0001, {12'h0, o_bank_open});
    cmd(RD, 2'h2, 12'h000);
    idle(4);
    chk("closed_rd", 16'h0000, {14'h0, o_dq_oe});
    cmd(XACT, 2'h1, 12'h000);
    idle(3);
    chk("deselect", 16'h0001, {12'h0, o_bank_open});
    cmd(PRE, 2'h3, 12'h400);
    idle(3);
    chk("pre_all", 16'h0000, {12'h0, o_bank_open});
    cmd(MRS, 2'h3, 12'h001);
    idle(3);
    chk("mode", 16'h3001, {2'h0, o_mode});
    cmd(ACT, 2'h1, 12'h005);
    idle(1);
    cmd(WR, 2'h1, 12'h004, 2'h0, 16'h1111);
    cmd(NOP, 2'h1, 12'h000, 2'h0, 16'h2222);
    cmd(WR, 2'h1, 12'h008, 2'h0, 16'h3333);
    cmd(BST, 2'h1, 12'h000, 2'h0, 16'h4444);
    cmd(RD, 2'h1, 12'h004);
    idle(3);
    chk("beat0", 16'h1111, o_dq);
    @(posedge i_mclk);
    #1;
    chk("beat1", 16'h2222, o_dq);
    cmd(RD, 2'h1, 12'h009);
    idle(3);
    chk("cut", 16'h0000, o_dq);
    cmd(PRE, 2'h0, 12'h400);
    idle(3);
    // Length four, interleaved, latency three, single-column writes
    cmd(MRS, 2'h0, 12'h23a);
    idle(3);
    cmd(ACT, 2'h1, 12'h005);
    idle(1);
    cmd(WR, 2'h1, 12'h006, 2'h0, 16'h6666);
    cmd(RD, 2'h1, 12'h005);
    idle(4);
    foreach (BEATS[i]) begin
      chk("ilv", BEATS[i], o_dq);
      @(posedge i_mclk);
      #1;
    end
    cmd(PRE, 2'h0, 12'h400);
    idle(3);
    for (int i = 0; i < 3; i++) begin
      cmd(REF, 2'h0, 12'h000);
      idle(2);
      chk("ref", 16'h0001, {15'h0, o_refresh});
      chk("ref_row", 16'(i), {4'h0, o_refresh_row});
    end
    cmd(SREF, 2'h0, 12'h000);
    cmd(5'h13, 2'h0, 12'h000);
    idle(2);
    chk("self", 16'h0001, {15'h0, o_self_refresh});
    @(posedge i_mclk);
    i_cke <= 1'b1;
    idle(6);
    chk("wake", 16'h0000, {11'h0, o_self_refresh, o_bank_open});
    finish_test();
  end
endmodule
